// >>> cgdc_pkg.sv
// constants for the colour graphics display controller
package cgdc_pkg;

  // ==========================================================
  // host i/o port addresses
  localparam logic [9:0] PORT_INDEX       = 10'h3D4;
  localparam logic [9:0] PORT_DATA        = 10'h3D5;
  localparam logic [9:0] PORT_MODE        = 10'h3D8;
  localparam logic [9:0] PORT_COLOUR      = 10'h3D9;
  localparam logic [9:0] PORT_STATUS      = 10'h3DA;
  localparam logic [9:0] PORT_PEN_CLEAR   = 10'h3DB;
  localparam logic [9:0] PORT_PEN_PRESET  = 10'h3DC;
  // timing ports answer anywhere in 3D0..3D7, bit 0 picks index/data
  localparam logic [6:0] PORT_CRTC_BLOCK  = 7'h7A;

  // ==========================================================
  // timing register indices
  localparam logic [4:0] IDX_H_TOTAL      = 5'h00;
  localparam logic [4:0] IDX_H_DISPLAYED  = 5'h01;
  localparam logic [4:0] IDX_H_SYNC_POS   = 5'h02;
  localparam logic [4:0] IDX_H_SYNC_WIDTH = 5'h03;
  localparam logic [4:0] IDX_V_TOTAL      = 5'h04;
  localparam logic [4:0] IDX_V_ADJUST     = 5'h05;
  localparam logic [4:0] IDX_V_DISPLAYED  = 5'h06;
  localparam logic [4:0] IDX_V_SYNC_POS   = 5'h07;
  localparam logic [4:0] IDX_INTERLACE    = 5'h08;
  localparam logic [4:0] IDX_MAX_SCAN     = 5'h09;
  localparam logic [4:0] IDX_CURSOR_START = 5'h0A;
  localparam logic [4:0] IDX_CURSOR_END   = 5'h0B;
  localparam logic [4:0] IDX_START_HIGH   = 5'h0C;
  localparam logic [4:0] IDX_START_LOW    = 5'h0D;
  localparam logic [4:0] IDX_CURSOR_HIGH  = 5'h0E;
  localparam logic [4:0] IDX_CURSOR_LOW   = 5'h0F;
  localparam logic [4:0] IDX_PEN_HIGH     = 5'h10;
  localparam logic [4:0] IDX_PEN_LOW      = 5'h11;
  localparam logic [4:0] IDX_WRITABLE_MAX = 5'h0F;

  // ==========================================================
  // mode control and colour select fields
  localparam int MODE_TEXT80   = 0;
  localparam int MODE_GRAPHICS = 1;
  localparam int MODE_VIDEO_EN = 3;
  localparam int MODE_HIRES_BW = 4;
  localparam int MODE_BLINK    = 5;
  localparam int COL_INTENSE   = 4;
  localparam int COL_SET       = 5;

  // ==========================================================
  // buffer layout and raster pacing
  localparam int         BUF_AW         = 14;
  localparam int         BUF_BYTES      = 16384;
  localparam int         BANK_BIT       = 13;
  localparam logic [3:0] PHASE_LAST_80  = 4'h7;
  localparam logic [3:0] PHASE_LAST_40  = 4'hF;
  localparam logic [4:0] VSYNC_LINES    = 5'h10;
  localparam int         CURSOR_BLINK   = 3;
  localparam int         CHAR_BLINK     = 4;

  // ==========================================================
  // reset values and fixed answers
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] READ_NONE      = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'hFF;

endpackage

// >>> cgdc_core.sv
// colour text and graphics display controller: ports, raster, buffer
//
// How it works
// - hires graphics: bit 7 shown first
// - odd graphics scan lines come from bank 0x2000 higher
// - text fetches character then attribute byte
// - characters shown in buffer order
// - host shares buffer equally except 80-column text
// - status shows vertical retrace
// - text dots come from fixed character generator
// - graphics dots fetched from 16K buffer
// - four-bit IRGB code decodes to 16 colours
// - index pointer selects one of 18 registers
// - index loaded by write to 3D4
// - index keeps only five low data bits
// - 0-13 write-only, cursor RW, pen read-only
// - decode mode, colour, status, pen ports
// - index/data ports ignore address bits 2,1
// - any write to 3DB clears pen trigger
`timescale 1ns/1ps
`default_nettype none

module cgdc_core (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // host i/o port bus
  input  wire logic [9:0]  ioAddr,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  input  wire logic [7:0]  ioWdata,
  output var  logic [7:0]  ioRdata,
  // host display buffer port
  input  wire logic [13:0] bufAddr,
  input  wire logic        bufWr,
  input  wire logic        bufRd,
  input  wire logic [7:0]  bufWdata,
  output var  logic [7:0]  bufRdata,
  output var  logic        bufAck,
  // light pen pins
  input  wire logic        penTrigger,
  input  wire logic        penSwitchN,
  // raster output
  output var  logic [1:0]  videoRed,
  output var  logic [1:0]  videoGreen,
  output var  logic [1:0]  videoBlue,
  output var  logic        hsyncOut,
  output var  logic        vsyncOut
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [15:0][7:0] crtc;
    logic [4:0]       index;
    logic [5:0]       modeCtl;
    logic [5:0]       colSel;
    logic [13:0]      penPos;
    logic             penTrig;
    logic [1:0]       penSync;
    logic             penPrev;
    logic [1:0]       swSync;
    logic [3:0]       phase;
    logic [7:0]       hChar;
    logic [4:0]       scan;
    logic [7:0]       row;
    logic             inAdjust;
    logic [4:0]       adjCnt;
    logic [4:0]       vsCnt;
    logic [13:0]      rowBase;
    logic [4:0]       frameCnt;
    logic [7:0]       charLatch;
    logic [15:0]      shiftReg;
    logic [7:0]       attrCur;
    logic             activeCur;
    logic             cursorCur;
    logic [1:0]       hostStage;
    logic [7:0]       bufRdata;
    logic             bufAck;
    logic [7:0]       ioRdata;
    logic [5:0]       video;
    logic             hsync;
    logic             vsync;
  } cgdc_state_t;

  cgdc_state_t s_reg;
  cgdc_state_t s_next;

  // ==========================================================
  // display buffer
  logic [7:0]  bufMem [cgdc_pkg::BUF_BYTES];
  logic [7:0]  memQ;
  logic [13:0] memAddr;
  logic        memWe;

  // ==========================================================
  // fixed character generator: deterministic dot pattern per code
  // and scan row; the bottom row stays blank as inter-line gap
  function automatic logic [7:0] cgdc_glyph(input logic [7:0] code,
                                            input logic [2:0] line);
    logic [15:0] twice;
    twice = {code, code} << line;
    cgdc_glyph = (line == 3'h7) ? 8'h00 : twice[15:8];
  endfunction

  // colour level per gun: base bit plus intensity, brown dims green
  function automatic logic [5:0] cgdc_colour(input logic [3:0] irgb);
    logic [1:0] g;
    g = {irgb[1], irgb[3]};
    if (irgb == 4'h6)
      g = 2'h1;
    cgdc_colour = {irgb[2], irgb[3], g, irgb[0], irgb[3]};
  endfunction

  // ==========================================================
  // combinational next state
  logic        text80;
  logic        gfx;
  logic        gfxHi;
  logic        fastDots;
  logic [3:0]  phaseLast;
  logic        charEnd;
  logic        secondSlot;
  logic        de;
  logic        hostReq;
  logic        hostGrant;
  logic [13:0] startAddr;
  logic [13:0] fetchAddr;
  logic [13:0] dispAddr;
  logic [13:0] cursorPos;
  logic        cursorHit;
  logic        crtcSel;
  logic        penEdge;
  logic        presetWr;
  logic        clearWr;
  logic [8:0]  hsEnd;
  logic        showDot;
  logic [3:0]  irgb;
  logic [3:0]  bgCode;
  logic [1:0]  pel;

  always_comb
  begin
    s_next = s_reg;

    text80   = ~s_reg.modeCtl[cgdc_pkg::MODE_GRAPHICS]
             & s_reg.modeCtl[cgdc_pkg::MODE_TEXT80];
    gfx      = s_reg.modeCtl[cgdc_pkg::MODE_GRAPHICS]
             | s_reg.modeCtl[cgdc_pkg::MODE_HIRES_BW];
    gfxHi    = s_reg.modeCtl[cgdc_pkg::MODE_HIRES_BW];
    fastDots = text80 | gfxHi;
    phaseLast  = text80 ? cgdc_pkg::PHASE_LAST_80
                        : cgdc_pkg::PHASE_LAST_40;
    charEnd    = s_reg.phase == phaseLast;
    secondSlot = s_reg.phase == phaseLast - 4'h1;

    de = (s_reg.hChar < s_reg.crtc[cgdc_pkg::IDX_H_DISPLAYED])
       & ~s_reg.inAdjust
       & (s_reg.row < s_reg.crtc[cgdc_pkg::IDX_V_DISPLAYED]);

    // byte address of the column being fetched; pairs stay on an
    // even/odd boundary because secondSlot replaces address bit 0
    startAddr = {s_reg.crtc[cgdc_pkg::IDX_START_HIGH][5:0],
                 s_reg.crtc[cgdc_pkg::IDX_START_LOW]};
    fetchAddr = startAddr + s_reg.rowBase
              + {5'h00, s_reg.hChar, 1'b0};
    fetchAddr[cgdc_pkg::BANK_BIT] = fetchAddr[cgdc_pkg::BANK_BIT]
              ^ (gfx & s_reg.scan[0]);
    dispAddr  = {fetchAddr[13:1], secondSlot};

    // host buffer slots: odd phases, or any cycle in 80-column text,
    // where the raster fetch then reads the host's byte instead
    hostReq   = (bufWr | bufRd) & (s_reg.hostStage == 2'h0)
              & ~s_reg.bufAck;
    hostGrant = hostReq & (s_reg.phase[0] | text80);
    memAddr   = hostGrant ? bufAddr : dispAddr;
    memWe     = hostGrant & bufWr;
    s_next.hostStage = {s_reg.hostStage[0], hostGrant};
    s_next.bufAck    = s_reg.hostStage[1];
    if (s_reg.hostStage[0])
      s_next.bufRdata = memQ;

    // ---------------- light pen
    s_next.penSync = {s_reg.penSync[0], penTrigger};
    s_next.swSync  = {s_reg.swSync[0], penSwitchN};
    s_next.penPrev = s_reg.penSync[1];
    penEdge  = s_reg.penSync[1] & ~s_reg.penPrev;
    presetWr = ioWr & (ioAddr == cgdc_pkg::PORT_PEN_PRESET);
    clearWr  = ioWr & (ioAddr == cgdc_pkg::PORT_PEN_CLEAR);
    if ((penEdge | presetWr) & ~s_reg.penTrig)
      s_next.penPos = fetchAddr;
    // a trigger in the clearing cycle still lands
    s_next.penTrig = (s_reg.penTrig & ~clearWr)
                   | penEdge | presetWr;

    // ---------------- host i/o writes
    crtcSel = ioAddr[9:3] == cgdc_pkg::PORT_CRTC_BLOCK;
    if (ioWr & crtcSel & ~ioAddr[0])
      s_next.index = ioWdata[4:0];
    if (ioWr & crtcSel & ioAddr[0]
        & (s_reg.index <= cgdc_pkg::IDX_WRITABLE_MAX))
      s_next.crtc[s_reg.index[3:0]] = ioWdata;
    if (ioWr & (ioAddr == cgdc_pkg::PORT_MODE))
      s_next.modeCtl = ioWdata[5:0];
    if (ioWr & (ioAddr == cgdc_pkg::PORT_COLOUR))
      s_next.colSel = ioWdata[5:0];

    // ---------------- host i/o reads
    if (ioRd)
    begin
      s_next.ioRdata = cgdc_pkg::READ_UNMAPPED;
      if (crtcSel & ioAddr[0])
      begin
        unique case (s_reg.index)
          cgdc_pkg::IDX_CURSOR_HIGH:
            s_next.ioRdata = s_reg.crtc[cgdc_pkg::IDX_CURSOR_HIGH];
          cgdc_pkg::IDX_CURSOR_LOW:
            s_next.ioRdata = s_reg.crtc[cgdc_pkg::IDX_CURSOR_LOW];
          cgdc_pkg::IDX_PEN_HIGH:
            s_next.ioRdata = {2'h0, s_reg.penPos[13:8]};
          cgdc_pkg::IDX_PEN_LOW:
            s_next.ioRdata = s_reg.penPos[7:0];
          default:
            s_next.ioRdata = cgdc_pkg::READ_NONE;
        endcase
      end
      else if (crtcSel)
        s_next.ioRdata = cgdc_pkg::READ_NONE;
      else if (ioAddr == cgdc_pkg::PORT_STATUS)
        s_next.ioRdata = {4'h0, s_reg.vsync, s_reg.swSync[1],
                          s_reg.penTrig, ~de};
      else if (ioAddr == cgdc_pkg::PORT_MODE
               || ioAddr == cgdc_pkg::PORT_COLOUR)
        s_next.ioRdata = cgdc_pkg::READ_NONE;
    end

    // ---------------- fetch: first byte is character or pixel byte
    if (s_reg.phase == phaseLast - 4'h2)
      s_next.charLatch = memQ;

    // ---------------- cursor match on the column being fetched
    cursorPos = {s_reg.crtc[cgdc_pkg::IDX_CURSOR_HIGH][5:0],
                 s_reg.crtc[cgdc_pkg::IDX_CURSOR_LOW]};
    cursorHit = ~gfx & (cursorPos[12:0] == fetchAddr[13:1])
              & (s_reg.scan >= s_reg.crtc[cgdc_pkg::IDX_CURSOR_START][4:0])
              & (s_reg.scan <= s_reg.crtc[cgdc_pkg::IDX_CURSOR_END][4:0]);

    // ---------------- dot shifter
    if (charEnd)
    begin
      if (gfx)
        s_next.shiftReg = {s_reg.charLatch, memQ};
      else
        s_next.shiftReg = {cgdc_glyph(s_reg.charLatch, s_reg.scan[2:0]),
                           8'h00};
      s_next.attrCur   = memQ;
      s_next.activeCur = de;
      s_next.cursorCur = cursorHit;
    end
    else if (fastDots | s_reg.phase[0])
    begin
      if (gfx & ~gfxHi)
        s_next.shiftReg = {s_reg.shiftReg[13:0], 2'h0};
      else
        s_next.shiftReg = {s_reg.shiftReg[14:0], 1'b0};
    end

    // ---------------- pixel colour
    pel     = s_reg.shiftReg[15:14];
    bgCode  = s_reg.modeCtl[cgdc_pkg::MODE_BLINK]
            ? {1'b0, s_reg.attrCur[6:4]} : s_reg.attrCur[7:4];
    showDot = (s_reg.shiftReg[15]
               & ~(s_reg.modeCtl[cgdc_pkg::MODE_BLINK]
                   & s_reg.attrCur[7]
                   & s_reg.frameCnt[cgdc_pkg::CHAR_BLINK]))
            | (s_reg.cursorCur & s_reg.frameCnt[cgdc_pkg::CURSOR_BLINK]);
    if (~s_reg.modeCtl[cgdc_pkg::MODE_VIDEO_EN])
      irgb = 4'h0;
    else if (~s_reg.activeCur)
      irgb = gfxHi ? 4'h0 : s_reg.colSel[3:0];
    else if (gfxHi)
      irgb = s_reg.shiftReg[15] ? s_reg.colSel[3:0] : 4'h0;
    else if (gfx)
      irgb = (pel == 2'h0) ? s_reg.colSel[3:0]
           : {s_reg.colSel[cgdc_pkg::COL_INTENSE], pel,
              s_reg.colSel[cgdc_pkg::COL_SET]};
    else
      irgb = showDot ? s_reg.attrCur[3:0] : bgCode;
    s_next.video = cgdc_colour(irgb);

    // ---------------- horizontal and vertical counters
    s_next.phase = charEnd ? 4'h0 : s_reg.phase + 4'h1;
    hsEnd = {1'b0, s_reg.crtc[cgdc_pkg::IDX_H_SYNC_POS]}
          + {5'h00, s_reg.crtc[cgdc_pkg::IDX_H_SYNC_WIDTH][3:0]};
    s_next.hsync = (s_reg.hChar >= s_reg.crtc[cgdc_pkg::IDX_H_SYNC_POS])
                 & ({1'b0, s_reg.hChar} < hsEnd);
    if (charEnd)
    begin
      s_next.hChar = s_reg.hChar + 8'h01;
      if (s_reg.hChar == s_reg.crtc[cgdc_pkg::IDX_H_TOTAL])
      begin
        s_next.hChar = 8'h00;
        if (s_reg.vsCnt != 5'h00)
          s_next.vsCnt = s_reg.vsCnt - 5'h01;
        if (s_reg.inAdjust)
        begin
          s_next.adjCnt = s_reg.adjCnt + 5'h01;
          if (s_reg.adjCnt + 5'h01
              >= s_reg.crtc[cgdc_pkg::IDX_V_ADJUST][4:0])
          begin
            s_next.inAdjust = 1'b0;
            s_next.row      = 8'h00;
            s_next.rowBase  = 14'h0000;
            s_next.frameCnt = s_reg.frameCnt + 5'h01;
          end
        end
        else if (s_reg.scan == s_reg.crtc[cgdc_pkg::IDX_MAX_SCAN][4:0])
        begin
          s_next.scan = 5'h00;
          if (s_reg.row == s_reg.crtc[cgdc_pkg::IDX_V_TOTAL])
          begin
            s_next.adjCnt = 5'h00;
            if (s_reg.crtc[cgdc_pkg::IDX_V_ADJUST][4:0] != 5'h00)
              s_next.inAdjust = 1'b1;
            else
            begin
              s_next.row      = 8'h00;
              s_next.rowBase  = 14'h0000;
              s_next.frameCnt = s_reg.frameCnt + 5'h01;
            end
          end
          else
          begin
            s_next.row = s_reg.row + 8'h01;
            // two bytes per column: 80 bytes per graphics line pair
            s_next.rowBase = s_reg.rowBase
              + {5'h00, s_reg.crtc[cgdc_pkg::IDX_H_DISPLAYED], 1'b0};
            if (s_reg.row + 8'h01
                == s_reg.crtc[cgdc_pkg::IDX_V_SYNC_POS])
              s_next.vsCnt = cgdc_pkg::VSYNC_LINES;
          end
        end
        else
          s_next.scan = s_reg.scan + 5'h01;
      end
    end
    s_next.vsync = s_next.vsCnt != 5'h00;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // buffer array needs no reset; contents are undefined at power-up
  always_ff @(posedge clock)
  begin
    if (memWe)
      bufMem[memAddr] <= bufWdata;
    memQ <= bufMem[memAddr];
  end

  // ==========================================================
  // outputs
  assign ioRdata    = s_reg.ioRdata;
  assign bufRdata   = s_reg.bufRdata;
  assign bufAck     = s_reg.bufAck;
  assign videoRed   = s_reg.video[5:4];
  assign videoGreen = s_reg.video[3:2];
  assign videoBlue  = s_reg.video[1:0];
  assign hsyncOut   = s_reg.hsync;
  assign vsyncOut   = s_reg.vsync;

endmodule

`default_nettype wire

// >>> cgdc_props.sv
// concurrent checks on the host side ports of the display controller
`timescale 1ns/1ps
`default_nettype none
module cgdc_props (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // i/o port bus
  input wire logic [9:0] ioAddr,
  input wire logic       ioRd,
  input wire logic [7:0] ioRdata,
  // buffer port
  input wire logic       bufRd,
  input wire logic       bufWr,
  input wire logic       bufAck
);
  // ==========================================================
  // buffer handshake
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ack_pulse_a: assert property (bufAck |=> !bufAck)
    else $error("buffer ack held longer than one cycle");
  ack_cause_a: assert property (bufAck |-> (bufRd | bufWr) &&
    $past(bufRd | bufWr, 2)) else $error("buffer ack without request");
  ack_bound_a: assert property ($rose(bufRd | bufWr) |-> ##[3:4] bufAck)
    else $error("buffer access not answered in time");

  // ==========================================================
  // i/o read answers
  rdata_hold_a: assert property ($changed(ioRdata) |-> $past(ioRd))
    else $error("read data moved without a read");
  index_wo_a: assert property (ioRd && ioAddr == cgdc_pkg::PORT_INDEX |=>
    ioRdata == cgdc_pkg::READ_NONE) else $error("index port readable");
  alias_index_a: assert property (ioRd && !ioAddr[0] &&
    ioAddr[9:3] == cgdc_pkg::PORT_CRTC_BLOCK |=>
    ioRdata == cgdc_pkg::READ_NONE) else $error("aliased index readable");
  mode_wo_a: assert property (ioRd && (ioAddr == cgdc_pkg::PORT_MODE ||
    ioAddr == cgdc_pkg::PORT_COLOUR) |=> ioRdata == cgdc_pkg::READ_NONE)
    else $error("mode or colour port readable");
  unmapped_read_a: assert property (ioRd &&
    ioAddr inside {10'h3DD, 10'h3DE, 10'h3DF} |=>
    ioRdata == cgdc_pkg::READ_UNMAPPED) else $error("unmapped port answered");
  status_high_a: assert property (ioRd &&
    ioAddr == cgdc_pkg::PORT_STATUS |=> ioRdata[7:4] == 4'h0)
    else $error("status unused bits set");
endmodule
`default_nettype wire

// >>> cgdc_host.sv
// host processor model: i/o port cycles and buffer accesses
`timescale 1ns/1ps
`default_nettype none
module cgdc_host (
  // clock
  input  wire logic        clock,
  // i/o port bus
  output var  logic [9:0]  ioAddr,
  output var  logic        ioWr,
  output var  logic        ioRd,
  output var  logic [7:0]  ioWdata,
  input  wire logic [7:0]  ioRdata,
  // buffer port
  output var  logic [13:0] bufAddr,
  output var  logic        bufWr,
  output var  logic        bufRd,
  output var  logic [7:0]  bufWdata,
  input  wire logic [7:0]  bufRdata,
  input  wire logic        bufAck
);
  initial
  begin
    ioAddr = 10'h000;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWdata = 8'h00;
    bufAddr = 14'h0000;
    bufWr = 1'b0;
    bufRd = 1'b0;
    bufWdata = 8'h00;
  end

  // ==========================================================
  // i/o cycles: one strobe cycle, released write data inverted
  task automatic ioWrite(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    ioAddr = a;
    ioWdata = d;
    ioWr = 1'b1;
    @(posedge clock);
    #1;
    ioWr = 1'b0;
    ioWdata = ~d;
  endtask

  task automatic ioRead(input logic [9:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    ioAddr = a;
    ioRd = 1'b1;
    @(posedge clock);
    #1;
    ioRd = 1'b0;
    d = ioRdata;
  endtask

  // ==========================================================
  // buffer access held until ack; n counts edges to the ack
  task automatic bufXfer(input logic w, input logic [13:0] a,
                         input logic [7:0] wd, output logic [7:0] rd,
                         output int n);
    @(posedge clock);
    #1;
    bufAddr = a;
    bufWdata = wd;
    bufWr = w;
    bufRd = !w;
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end while (bufAck !== 1'b1 && n < 8);
    rd = bufRdata;
    @(posedge clock);
    #1;
    bufWr = 1'b0;
    bufRd = 1'b0;
    bufAddr = ~a;
    bufWdata = ~wd;
  endtask
endmodule
`default_nettype wire

// >>> tb_cgdc_core.sv
// self-checking bench for the colour graphics display controller
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) chk(8'(g), 8'(e))
module tb_cgdc_core;
  logic        clock;
  logic        rst;
  logic [9:0]  ioAddr;
  logic        ioWr, ioRd;
  logic [7:0]  ioWdata, ioRdata;
  logic [13:0] bufAddr;
  logic        bufWr, bufRd, bufAck;
  logic [7:0]  bufWdata, bufRdata;
  logic        penTrigger, penSwitchN, vsyncOut, hsyncOut;
  logic [1:0]  videoRed, videoGreen, videoBlue;
  logic [7:0]  d;
  int          n, fail_count, cmp_count;
  // text 40-column timing set, start address even
  logic [7:0]  docTbl [14] = '{8'h38, 8'h28, 8'h2D, 8'h0A, 8'h1F, 8'h06,
    8'h19, 8'h1C, 8'h02, 8'h07, 8'h06, 8'h07, 8'h00, 8'h00};
  // shortened timing keeps one frame near four thousand clocks
  logic [7:0]  fastTbl [14] = '{8'h07, 8'h04, 8'h05, 8'h01, 8'h0F, 8'h00,
    8'h08, 8'h08, 8'h00, 8'h01, 8'h06, 8'h07, 8'h00, 8'h00};
  logic [9:0]  rdPort [5] = '{cgdc_pkg::PORT_INDEX, 10'h3D0,
    cgdc_pkg::PORT_MODE, cgdc_pkg::PORT_COLOUR, 10'h3DF};
  logic [7:0]  modes [4] = '{8'h08, 8'h09, 8'h0A, 8'h1A};
  // border codes brown, gray, bright white and their gun levels r:g:b
  logic [7:0]  colours [3] = '{8'h06, 8'h08, 8'h0F};
  logic [7:0]  levels [3] = '{8'h24, 8'h15, 8'h3F};

  always #2 clock = ~clock;

  cgdc_host u_host (.clock(clock), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWdata(ioWdata), .ioRdata(ioRdata), .bufAddr(bufAddr), .bufWr(bufWr),
    .bufRd(bufRd), .bufWdata(bufWdata), .bufRdata(bufRdata),
    .bufAck(bufAck));

  cgdc_core dut (.clock(clock), .rst(rst), .ioAddr(ioAddr), .ioWr(ioWr),
    .ioRd(ioRd), .ioWdata(ioWdata), .ioRdata(ioRdata), .bufAddr(bufAddr),
    .bufWr(bufWr), .bufRd(bufRd), .bufWdata(bufWdata),
    .bufRdata(bufRdata), .bufAck(bufAck), .penTrigger(penTrigger),
    .penSwitchN(penSwitchN), .videoRed(videoRed), .videoGreen(videoGreen),
    .videoBlue(videoBlue), .hsyncOut(hsyncOut), .vsyncOut(vsyncOut));

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic regWr(input logic [4:0] i, input logic [7:0] v);
    u_host.ioWrite(cgdc_pkg::PORT_INDEX, {3'h0, i});
    u_host.ioWrite(cgdc_pkg::PORT_DATA, v);
  endtask

  task automatic regRd(input logic [4:0] i, output logic [7:0] v);
    u_host.ioWrite(cgdc_pkg::PORT_INDEX, {3'h0, i});
    u_host.ioRead(cgdc_pkg::PORT_DATA, v);
  endtask

  task automatic waitVsync(input logic lvl);
    int k;
    k = 0;
    while (vsyncOut !== lvl && k < 20000)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k == 20000)
    begin
      fail_count++;
      end_sim;
    end
    repeat (4) @(posedge clock);
    #1;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    penTrigger = 1'b0;
    penSwitchN = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clock);
    #1;
    rst = 1'b0;
    regRd(cgdc_pkg::IDX_CURSOR_HIGH, d);
    `CHECK(d, cgdc_pkg::REG_RESET);
    regWr(cgdc_pkg::IDX_CURSOR_HIGH, 8'h12);
    regRd(cgdc_pkg::IDX_CURSOR_HIGH, d);
    `CHECK(d, 8'h12);
    u_host.ioWrite(10'h3D0, 8'hEF);
    u_host.ioWrite(10'h3D1, 8'h34);
    regRd(cgdc_pkg::IDX_CURSOR_LOW, d);
    `CHECK(d, 8'h34);
    u_host.ioWrite(10'h3D6, 8'h0E);
    u_host.ioRead(10'h3D7, d);
    `CHECK(d, 8'h12);
    $display("test cursor registers done");
    for (int i = 0; i < 14; i++)
    begin
      regWr(5'(i), docTbl[i]);
      regRd(5'(i), d);
      `CHECK(d, cgdc_pkg::READ_NONE);
    end
    regWr(cgdc_pkg::IDX_PEN_HIGH, 8'hAA);
    regRd(cgdc_pkg::IDX_PEN_HIGH, d);
    `CHECK(d, cgdc_pkg::REG_RESET);
    regRd(5'h12, d);
    `CHECK(d, cgdc_pkg::READ_NONE);
    for (int i = 0; i < 5; i++)
    begin
      u_host.ioRead(rdPort[i], d);
      `CHECK(d, i == 4 ? cgdc_pkg::READ_UNMAPPED : cgdc_pkg::READ_NONE);
    end
    $display("test register access done");
    for (int i = 0; i < 14; i++)
      regWr(5'(i), fastTbl[i]);
    u_host.ioWrite(cgdc_pkg::PORT_MODE, 8'h08);
    waitVsync(1'b1);
    u_host.ioRead(cgdc_pkg::PORT_STATUS, d);
    `CHECK(d[3], 1'b1);
    // retrace shows the border, so the colour select code drives the guns
    for (int i = 0; i < 3; i++)
    begin
      u_host.ioWrite(cgdc_pkg::PORT_COLOUR, colours[i]);
      @(posedge clock);
      #1;
      `CHECK({videoRed, videoGreen, videoBlue}, levels[i]);
    end
    n = 0;
    while (hsyncOut !== 1'b1 && n < 300)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHECK(hsyncOut, 1'b1);
    waitVsync(1'b0);
    u_host.ioRead(cgdc_pkg::PORT_STATUS, d);
    `CHECK(d[3], 1'b0);
    $display("test retrace status done");
    penSwitchN = 1'b0;
    u_host.ioWrite(cgdc_pkg::PORT_PEN_CLEAR, 8'h00);
    u_host.ioRead(cgdc_pkg::PORT_STATUS, d);
    `CHECK(d[2:1], 2'b00);
    penTrigger = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    penTrigger = 1'b0;
    penSwitchN = 1'b1;
    repeat (4) @(posedge clock);
    u_host.ioRead(cgdc_pkg::PORT_STATUS, d);
    `CHECK(d[2:1], 2'b11);
    u_host.ioWrite(cgdc_pkg::PORT_PEN_CLEAR, 8'hA5);
    u_host.ioRead(cgdc_pkg::PORT_STATUS, d);
    `CHECK(d[1], 1'b0);
    u_host.ioWrite(cgdc_pkg::PORT_PEN_PRESET, 8'h00);
    u_host.ioRead(cgdc_pkg::PORT_STATUS, d);
    `CHECK(d[1], 1'b1);
    $display("test light pen done");
    for (int i = 0; i < 4; i++)
    begin
      u_host.ioWrite(cgdc_pkg::PORT_MODE, modes[i]);
      if (i == 1)
        waitVsync(1'b1);
      u_host.bufXfer(1'b1, 14'h3FFF - 14'(i), 8'h5A ^ 8'(i), d, n);
      `CHECK(n inside {3, 4}, 1'b1);
      u_host.bufXfer(1'b0, 14'h3FFF - 14'(i), 8'h00, d, n);
      `CHECK(d, 8'h5A ^ 8'(i));
      if (i == 1)
        `CHECK(n, 3);
      else
        `CHECK(n inside {3, 4}, 1'b1);
    end
    $display("test buffer access done");
    end_sim;
  end
endmodule

bind cgdc_core cgdc_props u_props (.clock(clock), .rst(rst),
  .ioAddr(ioAddr), .ioRd(ioRd), .ioRdata(ioRdata), .bufRd(bufRd),
  .bufWr(bufWr), .bufAck(bufAck));
`default_nettype wire
